// *** fot_flash_ctrl.sv ***
// Chosen here: the register addresses and strobed register access.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// R1: Program suspend sets operation done about 7 us plus four clocks later.
// R2: Erase suspend sets operation done about 16 us plus four clocks later.
// R3: Clearing a suspend bit with high voltage on clears done promptly.
// R4: Rising high-voltage enable starts program or erase and clears done.
// R5: Falling high-voltage enable aborts the operation; done set within limit.
// R6: Leaving low power, flash is ready within 45 us plus seven clocks.
// R7: Rising integrity enable starts check and clears integrity done.
// R8: Resuming by clearing suspend or breakpoint-disable clears integrity done.
// R9: Integrity abort sets integrity done within 80 ns plus fifteen clocks.
// R10: Integrity suspend sets integrity done within 80 ns plus fifteen clocks.
// R11: Margin-read abort sets done 10.36 to 20.42 us plus four clocks later.
// R12: Margin-read suspend sets done in the same window as its abort.
// R13: Software programs wait states and pipelining per platform frequency.
// R14: Cache miss read takes wait states plus three clocks; hit takes one.
module fot_flash_ctrl
  import fot_pkg::*;
#(
  parameter int OP_CYCLES = 2000,
  parameter int AI_CYCLES = 1000
) (
  input  wire logic       mclk,
  input  wire logic       resetn,
  input  wire logic [7:0] addr,
  input  wire logic [31:0] wdata,
  input  wire logic       wr,
  input  wire logic       rd,
  output logic [31:0]     rdata,
  input  wire logic       flash_rd_req,
  input  wire logic       flash_rd_hit,
  output logic            flash_rd_ack,
  input  wire logic       ai_breakpoint,
  output logic            flash_ready,
  output logic            irq
);
  import fot_pkg::*;

  generate
    if (OP_CYCLES < 2 || OP_CYCLES >= (1 << TMR_W)) begin : g_bad_op
      $error("OP_CYCLES out of range");
    end
    if (AI_CYCLES < 2 || AI_CYCLES >= (1 << TMR_W)) begin : g_bad_ai
      $error("AI_CYCLES out of range");
    end
  endgenerate

  fot_tmr_if #(.W(TMR_W)) op_t ();
  fot_tmr_if #(.W(TMR_W)) ai_t ();
  fot_tmr_if #(.W(TMR_W)) lp_t ();
  fot_tmr_if #(.W(TMR_W)) rd_t ();

  fot_timer #(.W(TMR_W)) u_op_tmr (.mclk(mclk), .resetn(resetn), .t(op_t));
  fot_timer #(.W(TMR_W)) u_ai_tmr (.mclk(mclk), .resetn(resetn), .t(ai_t));
  fot_timer #(.W(TMR_W)) u_lp_tmr (.mclk(mclk), .resetn(resetn), .t(lp_t));
  fot_timer #(.W(TMR_W)) u_rd_tmr (.mclk(mclk), .resetn(resetn), .t(rd_t));

  logic [CFG_W-1:0] cfg_q;
  logic [UT_W-1:0]  ut_q;
  logic [2:0]       rd_wait_q;
  logic [1:0]       rd_pipe_q;
  logic [EV_W-1:0]  ev_q;
  logic [EV_W-1:0]  mask_q;
  logic             op_done_q;
  logic             ai_done_q;
  logic             ready_q;
  logic             rd_busy_q;
  logic [31:0]      rdata_q;
  fot_op_t          op_q;
  fot_ai_t          ai_q;

  logic wr_cfg;
  logic wr_ut;
  logic hv_rise;
  logic hv_fall;
  logic psus_rise;
  logic esus_rise;
  logic sus_clear;
  logic chk_rise;
  logic chk_fall;
  logic chk_sus_rise;
  logic ai_resume;
  logic lp_exit;
  logic op_done_set;
  logic ai_done_set;
  logic ready_set;
  logic [3:0] miss_lat;

  assign wr_cfg       = wr && (addr == OFF_MODULE_CFG);
  assign wr_ut        = wr && (addr == OFF_USER_TEST0);
  assign hv_rise      = wr_cfg && wdata[CFG_HV] && !cfg_q[CFG_HV];
  assign hv_fall      = wr_cfg && !wdata[CFG_HV] && cfg_q[CFG_HV];
  assign psus_rise    = wr_cfg && wdata[CFG_PSUS] && !cfg_q[CFG_PSUS];
  assign esus_rise    = wr_cfg && wdata[CFG_ESUS] && !cfg_q[CFG_ESUS];
  assign sus_clear    = wr_cfg && wdata[CFG_HV] && !wdata[CFG_PSUS] && !wdata[CFG_ESUS];
  assign chk_rise     = wr_ut && wdata[UT_ENABLE] && !ut_q[UT_ENABLE];
  assign chk_fall     = wr_ut && !wdata[UT_ENABLE] && ut_q[UT_ENABLE];
  assign chk_sus_rise = wr_ut && wdata[UT_SUSPEND] && !ut_q[UT_SUSPEND];
  assign ai_resume    = wr_ut && wdata[UT_ENABLE] && !wdata[UT_SUSPEND] &&
                        (ut_q[UT_SUSPEND] || (ut_q[UT_BP_DIS] && !wdata[UT_BP_DIS]));
  assign lp_exit      = wr_cfg && !wdata[CFG_LOW_POWER] && cfg_q[CFG_LOW_POWER];

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      cfg_q <= CFG_RESET;
    end else if (wr_cfg) begin
      cfg_q <= wdata[CFG_W-1:0];
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      ut_q <= UT_RESET;
    end else if (wr_ut) begin
      ut_q <= wdata[UT_W-1:0];
    end
  end

  // Program and erase sequencing; an abort outranks suspend and resume.
  always_comb begin
    op_t.load   = 1'b0;
    op_t.value  = '0;
    op_done_set = 1'b0;
    if (hv_rise && (op_q == OP_IDLE)) begin
      op_t.load  = 1'b1;
      op_t.value = TMR_W'(OP_CYCLES);
    end else if (hv_fall && (op_q != OP_IDLE)) begin
      op_t.load  = 1'b1;
      op_t.value = ABORT_CYC;                                  // [R5]
    end else if ((op_q == OP_RUN) && psus_rise) begin
      op_t.load  = 1'b1;
      op_t.value = PSUS_CYC;                                   // [R1]
    end else if ((op_q == OP_RUN) && esus_rise) begin
      op_t.load  = 1'b1;
      op_t.value = ESUS_CYC;                                   // [R2]
    end else if ((op_q == OP_SUSPENDED) && sus_clear) begin
      // The suspended operation restarts its full interval on resume.
      op_t.load  = 1'b1;
      op_t.value = TMR_W'(OP_CYCLES);
    end else if (op_t.expired && (op_q != OP_IDLE) && (op_q != OP_SUSPENDED)) begin
      op_done_set = 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      op_q <= OP_IDLE;
    end else begin
      case (op_q)
        OP_IDLE: begin
          if (hv_rise) op_q <= OP_RUN;
        end
        OP_RUN: begin
          if (hv_fall) op_q <= OP_ABORTING;
          else if (psus_rise || esus_rise) op_q <= OP_SUSPENDING;
          else if (op_t.expired) op_q <= OP_IDLE;
        end
        OP_SUSPENDING: begin
          if (hv_fall) op_q <= OP_ABORTING;
          else if (op_t.expired) op_q <= OP_SUSPENDED;
        end
        OP_SUSPENDED: begin
          if (hv_fall) op_q <= OP_ABORTING;
          else if (sus_clear) op_q <= OP_RUN;
        end
        OP_ABORTING: begin
          if (op_t.expired) op_q <= OP_IDLE;
        end
        default: op_q <= OP_IDLE;
      endcase
    end
  end

  // Done clears on the write edge itself, the earliest a clocked flag can move.
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      op_done_q <= 1'b1;
    end else if (op_done_set) begin
      op_done_q <= 1'b1;
    end else if (hv_rise && (op_q == OP_IDLE)) begin
      op_done_q <= 1'b0;                                       // [R4]
    end else if ((op_q == OP_SUSPENDED) && sus_clear && !hv_fall) begin
      op_done_q <= 1'b0;                                       // [R3]
    end
  end

  // Margin read and array integrity sequencing.
  always_comb begin
    ai_t.load   = 1'b0;
    ai_t.value  = '0;
    ai_done_set = 1'b0;
    if (chk_rise && (ai_q == AI_IDLE)) begin
      ai_t.load  = 1'b1;
      ai_t.value = TMR_W'(AI_CYCLES);
    end else if (chk_fall && (ai_q != AI_IDLE) && (ai_q != AI_STOPPING)) begin
      ai_t.load  = 1'b1;
      ai_t.value = ut_q[UT_MARGIN] ? MRSTOP_CYC : AISTOP_CYC;  // [R9] [R11]
    end else if ((ai_q == AI_RUN) && chk_sus_rise) begin
      ai_t.load  = 1'b1;
      ai_t.value = ut_q[UT_MARGIN] ? MRSTOP_CYC : AISTOP_CYC;  // [R10] [R12]
    end else if ((ai_q == AI_HELD) && ai_resume) begin
      ai_t.load  = 1'b1;
      ai_t.value = TMR_W'(AI_CYCLES);
    end else if ((ai_q == AI_RUN) && ai_breakpoint && ut_q[UT_BP_DIS]) begin
      ai_done_set = 1'b1;
    end else if (ai_t.expired && (ai_q != AI_IDLE) && (ai_q != AI_HELD)) begin
      ai_done_set = 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      ai_q <= AI_IDLE;
    end else begin
      case (ai_q)
        AI_IDLE: begin
          if (chk_rise) ai_q <= AI_RUN;
        end
        AI_RUN: begin
          if (chk_fall) ai_q <= AI_STOPPING;
          else if (chk_sus_rise) ai_q <= AI_SUSPENDING;
          else if (ai_breakpoint && ut_q[UT_BP_DIS]) ai_q <= AI_HELD;
          else if (ai_t.expired) ai_q <= AI_IDLE;
        end
        AI_SUSPENDING: begin
          if (chk_fall) ai_q <= AI_STOPPING;
          else if (ai_t.expired) ai_q <= AI_HELD;
        end
        AI_HELD: begin
          if (chk_fall) ai_q <= AI_STOPPING;
          else if (ai_resume) ai_q <= AI_RUN;
        end
        AI_STOPPING: begin
          if (ai_t.expired) ai_q <= AI_IDLE;
        end
        default: ai_q <= AI_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      ai_done_q <= 1'b1;
    end else if (ai_done_set) begin
      ai_done_q <= 1'b1;
    end else if (chk_rise && (ai_q == AI_IDLE)) begin
      ai_done_q <= 1'b0;                                       // [R7]
    end else if ((ai_q == AI_HELD) && ai_resume) begin
      ai_done_q <= 1'b0;                                       // [R8]
    end
  end

  // Entering low power drops ready at once; leaving it waits for recovery.
  assign lp_t.load  = lp_exit;
  assign lp_t.value = RECOV_CYC;                               // [R6]
  assign ready_set  = lp_t.expired && !cfg_q[CFG_LOW_POWER];

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      ready_q <= 1'b1;
    end else if (wr_cfg && wdata[CFG_LOW_POWER]) begin
      ready_q <= 1'b0;
    end else if (ready_set) begin
      ready_q <= 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      rd_wait_q <= WAIT_RESET;
      rd_pipe_q <= PIPE_RESET;
    end else if (wr && (addr == OFF_PORT_CFG1)) begin
      rd_wait_q <= wdata[PC_WAIT_LSB +: 3];                    // [R13]
      rd_pipe_q <= wdata[PC_PIPE_LSB +: 2];
    end
  end

  // Reads are refused while one is pending or the array is not ready.
  assign miss_lat     = MISS_BASE + {1'b0, rd_wait_q};         // [R14]
  assign rd_t.load    = flash_rd_req && !rd_busy_q && ready_q;
  assign rd_t.value   = TMR_W'(flash_rd_hit ? HIT_LATENCY : miss_lat);
  assign flash_rd_ack = rd_busy_q && rd_t.expired;

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      rd_busy_q <= 1'b0;
    end else if (rd_t.load) begin
      rd_busy_q <= 1'b1;
    end else if (flash_rd_ack) begin
      rd_busy_q <= 1'b0;
    end
  end

  // Sticky events; a new event beats a write-one-to-clear in the same cycle.
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      ev_q <= '0;
    end else begin
      ev_q <= (ev_q & ~((wr && (addr == OFF_IRQ_STATUS)) ? wdata[EV_W-1:0] : '0))
              | {ready_set, ai_done_set, op_done_set};
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      mask_q <= '0;
    end else if (wr && (addr == OFF_IRQ_MASK)) begin
      mask_q <= wdata[EV_W-1:0];
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      rdata_q <= '0;
    end else if (rd) begin
      case (addr)
        OFF_MODULE_CFG: rdata_q <= 32'(cfg_q);
        OFF_STATUS:     rdata_q <= 32'({ready_q, (op_q != OP_IDLE), op_done_q});
        OFF_USER_TEST0: rdata_q <= 32'({ai_done_q, ut_q});
        OFF_PORT_CFG1:  rdata_q <= 32'({miss_lat, 2'h0, rd_pipe_q, 1'b0, rd_wait_q});
        OFF_IRQ_STATUS: rdata_q <= 32'(ev_q);
        OFF_IRQ_MASK:   rdata_q <= 32'(mask_q);
        default:        rdata_q <= '0;
      endcase
    end else begin
      rdata_q <= '0;
    end
  end

  assign rdata       = rdata_q;
  assign flash_ready = ready_q;
  assign irq         = |(ev_q & mask_q);
endmodule : fot_flash_ctrl
`default_nettype wire

// *** fot_flash_ctrl_assertions.sv ***
`timescale 1ns/1ps
`default_nettype none
module fot_flash_ctrl_assertions
  import fot_pkg::*;
#(
  parameter int OP_CYCLES = 2000,
  parameter int AI_CYCLES = 1000
) (
  input wire logic        mclk,
  input wire logic        resetn,
  input wire logic [7:0]  addr,
  input wire logic [31:0] wdata,
  input wire logic        wr,
  input wire logic        rd,
  input wire logic [31:0] rdata,
  input wire logic        flash_rd_req,
  input wire logic        flash_rd_hit,
  input wire logic        flash_rd_ack,
  input wire logic        ai_breakpoint,
  input wire logic        flash_ready,
  input wire logic        irq
);
  logic        pend_q;
  logic [3:0]  lat_q;
  logic [3:0]  exp_q;
  logic [2:0]  rd_wait_q;
  logic [2:0]  mask_q;
  logic        lp_q;
  logic [11:0] rcnt_q;
  logic        take;

  assign take = flash_rd_req && !pend_q && flash_ready;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  // The expected latency is frozen at acceptance, so a later settings write cannot move it.
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      pend_q <= 1'b0;
      lat_q  <= 4'h0;
      exp_q  <= 4'h0;
    end else if (take) begin
      pend_q <= 1'b1;
      lat_q  <= 4'h1;
      exp_q  <= flash_rd_hit ? HIT_LATENCY : MISS_BASE + 4'(rd_wait_q);
    end else if (flash_rd_ack) begin
      pend_q <= 1'b0;
    end else if (pend_q && lat_q != 4'hF) begin
      lat_q <= lat_q + 4'h1;
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      rd_wait_q <= WAIT_RESET;
      mask_q    <= 3'h0;
      lp_q      <= 1'b0;
    end else if (wr) begin
      if (addr == OFF_PORT_CFG1) rd_wait_q <= wdata[2:0];
      if (addr == OFF_IRQ_MASK) mask_q <= wdata[2:0];
      if (addr == OFF_MODULE_CFG) lp_q <= wdata[CFG_LOW_POWER];
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn || (wr && addr == OFF_MODULE_CFG)) begin
      rcnt_q <= 12'h000;
    end else if (!flash_ready && rcnt_q != 12'hFFF) begin
      rcnt_q <= rcnt_q + 12'h001;
    end
  end

  rdata_idle_a: assert property (!rd |=> rdata == 32'h0)
    else $error("read data not zero after idle cycle");
  unmapped_read_a: assert property ((rd && addr > OFF_IRQ_MASK) |=> rdata == 32'h0)
    else $error("unmapped read returned data");
  irq_masked_a: assert property ((mask_q == 3'h0) |-> !irq)
    else $error("interrupt raised with all sources masked");
  ack_pulse_a: assert property (flash_rd_ack |=> !flash_rd_ack)
    else $error("read ack longer than one cycle");
  ack_pending_a: assert property (flash_rd_ack |-> pend_q)
    else $error("read ack without accepted request");
  ack_latency_a: assert property (flash_rd_ack |-> lat_q == exp_q)
    else $error("read ack at wrong latency");
  lp_ready_low_a: assert property ((wr && addr == OFF_MODULE_CFG && wdata[CFG_LOW_POWER])
    |=> !flash_ready)
    else $error("ready stayed high on low power entry");
  recov_bound_a: assert property ((!lp_q && !flash_ready) |-> rcnt_q <= RECOV_CYC)
    else $error("recovery from low power too slow");
  ready_rise_a: assert property ($rose(flash_ready) |-> !lp_q)
    else $error("ready rose while in low power");

  hit_read_c: cover property (take && flash_rd_hit);
  miss_read_c: cover property (take && !flash_rd_hit);
  recovery_c: cover property ($rose(flash_ready));
  irq_c: cover property (irq);
endmodule : fot_flash_ctrl_assertions
`default_nettype wire

// *** fot_pkg.sv ***
package fot_pkg;

  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned TMR_W         = 12;

  // Register word offsets (byte addresses).
  localparam logic [7:0] OFF_MODULE_CFG = 8'h00;
  localparam logic [7:0] OFF_STATUS     = 8'h04;
  localparam logic [7:0] OFF_USER_TEST0 = 8'h08;
  localparam logic [7:0] OFF_PORT_CFG1  = 8'h0C;
  localparam logic [7:0] OFF_IRQ_STATUS = 8'h10;
  localparam logic [7:0] OFF_IRQ_MASK   = 8'h14;

  // flash_module_config_reg fields.
  localparam int unsigned CFG_HV        = 0;
  localparam int unsigned CFG_PSUS      = 1;
  localparam int unsigned CFG_ESUS      = 2;
  localparam int unsigned CFG_LOW_POWER = 3;
  localparam int unsigned CFG_W         = 4;
  localparam logic [3:0]  CFG_RESET     = 4'h0;

  // Status fields.
  localparam int unsigned ST_OP_DONE = 0;
  localparam int unsigned ST_BUSY    = 1;
  localparam int unsigned ST_READY   = 2;

  // user_test_reg0 fields; bit 4 is the read-only done flag.
  localparam int unsigned UT_ENABLE  = 0;
  localparam int unsigned UT_SUSPEND = 1;
  localparam int unsigned UT_BP_DIS  = 2;
  localparam int unsigned UT_MARGIN  = 3;
  localparam int unsigned UT_DONE    = 4;
  localparam int unsigned UT_W      = 4;
  localparam logic [3:0]  UT_RESET  = 4'h0;

  // flash_port_config1 fields.
  localparam int unsigned PC_WAIT_LSB = 0;
  localparam int unsigned PC_PIPE_LSB = 4;
  localparam int unsigned PC_LAT_LSB  = 8;
  localparam logic [2:0]  WAIT_RESET  = 3'h0;
  localparam logic [1:0]  PIPE_RESET  = 2'h0;
  localparam logic [3:0]  MISS_BASE   = 4'h3;
  localparam logic [3:0]  HIT_LATENCY = 4'h1;

  // Interrupt event bits.
  localparam int unsigned EV_OP_DONE = 0;
  localparam int unsigned EV_AI_DONE = 1;
  localparam int unsigned EV_READY   = 2;
  localparam int unsigned EV_W       = 3;

  // Times in ns as printed, and clock counts derived from them.
  localparam int unsigned T_PSUS_NS   = 7000;
  localparam int unsigned T_ESUS_NS   = 16000;
  localparam int unsigned T_ABORT_NS  = 16000;
  localparam int unsigned T_RECOV_NS  = 45000;
  localparam int unsigned T_AISTOP_NS = 80;
  localparam int unsigned T_MRSTOP_NS = 10360;
  localparam logic [11:0] PSUS_CYC   = 12'(T_PSUS_NS / CLK_PERIOD_NS + 4);
  localparam logic [11:0] ESUS_CYC   = 12'(T_ESUS_NS / CLK_PERIOD_NS + 4);
  localparam logic [11:0] ABORT_CYC  = 12'(T_ABORT_NS / CLK_PERIOD_NS + 4);
  localparam logic [11:0] RECOV_CYC  = 12'(T_RECOV_NS / CLK_PERIOD_NS + 7);
  localparam logic [11:0] AISTOP_CYC = 12'(T_AISTOP_NS / CLK_PERIOD_NS + 15);
  localparam logic [11:0] MRSTOP_CYC =
    12'((T_MRSTOP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 4);

  typedef enum {OP_IDLE, OP_RUN, OP_SUSPENDING, OP_SUSPENDED, OP_ABORTING} fot_op_t;
  typedef enum {AI_IDLE, AI_RUN, AI_STOPPING, AI_SUSPENDING, AI_HELD} fot_ai_t;

endpackage : fot_pkg

// *** fot_timer.sv ***
`timescale 1ns/1ps
`default_nettype none
module fot_timer #(
  parameter int W = 12
) (
  input  wire logic mclk,
  input  wire logic resetn,
  fot_tmr_if.tmr    t
);
  logic [W-1:0] cnt_q;

  // A load of N makes expired pulse N cycles after the load cycle.
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      cnt_q <= '0;
    end else if (t.load) begin
      cnt_q <= t.value;
    end else if (cnt_q != '0) begin
      cnt_q <= cnt_q - W'(1);
    end
  end

  assign t.expired = (cnt_q == W'(1)) && !t.load;
endmodule : fot_timer
`default_nettype wire

// *** fot_tmr_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface fot_tmr_if #(parameter int W = 12);
  logic         load;
  logic [W-1:0] value;
  logic         expired;
  modport ctl (output load, output value, input expired);
  modport tmr (input load, input value, output expired);
endinterface : fot_tmr_if
`default_nettype wire

// *** test_fot_flash_ctrl.sv ***
`timescale 1ns/1ps
`default_nettype none
module test_fot_flash_ctrl;
  import fot_pkg::*;
  localparam int OP_N  = 900;
  localparam int AI_N  = 1200;
  localparam int MR_LO = 10360 / 20 + 4;
  localparam int MR_HI = 20420 / 20 + 4 + 1;
  localparam logic [2:0] RWV   [3] = '{3'h0, 3'h2, 3'h3};
  localparam logic [1:0] APCV  [3] = '{2'h0, 2'h1, 2'h1};
  localparam logic [3:0] MISSV [3] = '{4'h3, 4'h5, 4'h6};
  logic        mclk = 1'b0;
  logic        resetn = 1'b0;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic        flash_rd_req = 1'b0;
  logic        flash_rd_hit = 1'b0;
  logic        ai_breakpoint = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata;
  logic        flash_rd_ack;
  logic        flash_ready;
  logic        irq;
  int          error_cnt = 0;
  int          checks_done = 0;

  always #10 mclk = ~mclk;

  fot_flash_ctrl #(.OP_CYCLES(OP_N), .AI_CYCLES(AI_N)) i_fot_flash_ctrl (
    .mclk(mclk), .resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .flash_rd_req(flash_rd_req), .flash_rd_hit(flash_rd_hit),
    .flash_rd_ack(flash_rd_ack), .ai_breakpoint(ai_breakpoint),
    .flash_ready(flash_ready), .irq(irq));

  task automatic conclude();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : conclude

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] got);
    checks_done++;
    if (got !== e) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, e, got);
    end
  endtask : chk

  // Every task but idle(0) returns 1 ns after a rising edge; idle(0) only waits 1 ns, so the next task starts 2 ns after one.
  task automatic idle(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : idle

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge mclk);
    wr <= 1'b0;
    #1;
  endtask : wr_reg

  task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
                      input string nm);
    rd <= 1'b1;
    addr <= a;
    @(posedge mclk);
    rd <= 1'b0;
    #1;
    chk(nm, e, rdata & m);
  endtask : rchk

  // Flag must read 0 in cycle 1 and cycle lo after the write, and set by cycle hi.
  task automatic timed(input logic [7:0] a, input logic [31:0] d, input logic [7:0] sa,
                       input logic [31:0] m, input int lo, input int hi, input string nm);
    wr_reg(a, d);
    rchk(sa, m, 32'h0, nm);
    idle(lo - 2);
    rchk(sa, m, 32'h0, nm);
    idle(hi - lo - 1);
    rchk(sa, m, m, nm);
  endtask : timed

  // The wait lets any abort from a held state finish before the next start.
  task automatic restart(input logic [7:0] a, input logic [31:0] d);
    wr_reg(a, 32'h0);
    idle(MR_HI);
    wr_reg(a, d);
  endtask : restart

  task automatic frd(input logic h, input int e);
    int n;
    n = 1;
    flash_rd_req <= 1'b1;
    flash_rd_hit <= h;
    @(posedge mclk);
    flash_rd_req <= 1'b0;
    #1;
    while (flash_rd_ack !== 1'b1 && n < 20) begin
      idle(1);
      n++;
    end
    chk("read latency", 32'(e), 32'(n));
    idle(1);
  endtask : frd

  initial begin
    repeat (8) @(posedge mclk);
    resetn <= 1'b1;
    #1;
    rchk(OFF_STATUS, 32'h7, 32'h5, "status reset");
    rchk(OFF_MODULE_CFG, 32'hF, 32'h0, "cfg reset");
    rchk(OFF_USER_TEST0, 32'h1F, 32'h10, "test reg reset");
    rchk(OFF_PORT_CFG1, 32'hFFF, 32'h300, "port cfg reset");
    rchk(OFF_IRQ_MASK, 32'h7, 32'h0, "mask reset");
    wr_reg(8'h40, 32'hFFFF_FFFF);
    rchk(8'h40, 32'hFFFF_FFFF, 32'h0, "unmapped");
    timed(OFF_MODULE_CFG, 1, OFF_STATUS, 1, OP_N, OP_N + 1, "op done");
    rchk(OFF_IRQ_STATUS, 32'h1, 32'h1, "op event");
    chk("irq masked", 32'h0, 32'(irq));
    wr_reg(OFF_IRQ_MASK, 32'h1);
    chk("irq raised", 32'h1, 32'(irq));
    wr_reg(OFF_IRQ_STATUS, 32'h1);
    rchk(OFF_IRQ_STATUS, 32'h1, 32'h0, "op event cleared");
    chk("irq cleared", 32'h0, 32'(irq));
    wr_reg(OFF_IRQ_MASK, 32'h0);
    restart(OFF_MODULE_CFG, 1);
    timed(OFF_MODULE_CFG, 3, OFF_STATUS, 1, PSUS_CYC, PSUS_CYC + 1, "psus");
    timed(OFF_MODULE_CFG, 1, OFF_STATUS, 1, OP_N, OP_N + 1, "resume");
    restart(OFF_MODULE_CFG, 1);
    timed(OFF_MODULE_CFG, 5, OFF_STATUS, 1, ESUS_CYC, ESUS_CYC + 1, "esus");
    timed(OFF_MODULE_CFG, 1, OFF_STATUS, 1, OP_N, OP_N + 1, "resume");
    restart(OFF_MODULE_CFG, 1);
    timed(OFF_MODULE_CFG, 0, OFF_STATUS, 1, ABORT_CYC, ABORT_CYC + 1, "abort");
    wr_reg(OFF_MODULE_CFG, 32'h8);
    chk("ready pin low", 32'h0, 32'(flash_ready));
    timed(OFF_MODULE_CFG, 0, OFF_STATUS, 4, RECOV_CYC, RECOV_CYC + 1, "recovery");
    chk("ready pin", 32'h1, 32'(flash_ready));
    timed(OFF_USER_TEST0, 1, OFF_USER_TEST0, 16, AI_N, AI_N + 1, "check");
    rchk(OFF_IRQ_STATUS, 32'h6, 32'h6, "check and ready events");
    restart(OFF_USER_TEST0, 1);
    timed(OFF_USER_TEST0, 0, OFF_USER_TEST0, 16, AISTOP_CYC, AISTOP_CYC + 1, "ai abort");
    restart(OFF_USER_TEST0, 1);
    timed(OFF_USER_TEST0, 3, OFF_USER_TEST0, 16, AISTOP_CYC, AISTOP_CYC + 1, "ai susp");
    timed(OFF_USER_TEST0, 1, OFF_USER_TEST0, 16, AI_N, AI_N + 1, "ai resume");
    restart(OFF_USER_TEST0, 9);
    timed(OFF_USER_TEST0, 8, OFF_USER_TEST0, 16, MR_LO, MR_HI, "mr abort");
    restart(OFF_USER_TEST0, 9);
    timed(OFF_USER_TEST0, 11, OFF_USER_TEST0, 16, MR_LO, MR_HI, "mr susp");
    restart(OFF_USER_TEST0, 5);
    ai_breakpoint <= 1'b1;
    @(posedge mclk);
    ai_breakpoint <= 1'b0;
    idle(30);
    rchk(OFF_USER_TEST0, 32'h10, 32'h10, "bp hold");
    timed(OFF_USER_TEST0, 1, OFF_USER_TEST0, 16, AI_N, AI_N + 1, "bp resume");
    for (int i = 0; i < 3; i++) begin
      wr_reg(OFF_PORT_CFG1, {26'h0, APCV[i], 1'b0, RWV[i]});
      rchk(OFF_PORT_CFG1, 32'hFFF, {20'h0, MISSV[i], 2'h0, APCV[i], 1'b0, RWV[i]}, "port");
      frd(1'b0, MISSV[i]);
      frd(1'b1, 1);
    end
    conclude();
  end

  initial begin
    repeat (40000) @(posedge mclk);
    error_cnt++;
    conclude();
  end
endmodule : test_fot_flash_ctrl

bind fot_flash_ctrl fot_flash_ctrl_assertions #(.OP_CYCLES(OP_CYCLES), .AI_CYCLES(AI_CYCLES))
  i_fot_flash_ctrl_assertions (
    .mclk(mclk), .resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .flash_rd_req(flash_rd_req), .flash_rd_hit(flash_rd_hit),
    .flash_rd_ack(flash_rd_ack), .ai_breakpoint(ai_breakpoint),
    .flash_ready(flash_ready), .irq(irq));
`default_nettype wire
